// File: logic/cas_core.sv
// Accumulator ALU, flags, multiplier and two-stage fetch behind APB
`timescale 1ns/1ps
`include "cas_regs.svh"

module cas_core import cas_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] pm_addr,
  output logic pm_ext,
  input wire logic [15:0] pm_data
);

  ////////////////////////////////////////////////////////////////////
  // State
  logic [3:0] ctrl_reg; // Run, mode, protect
  logic [7:0] acc_reg; // Accumulator
  cas_flags_t stat_reg; // Arithmetic flags
  logic [7:0] ptr_reg; // Indirect pointer
  logic [15:0] prod_reg; // Product or table word
  logic [15:0] pc_reg; // Program counter
  cas_instr_t ir_reg; // Word in execute
  cas_state_t st_reg; // Sequencer state
  cas_state_t st_next;
  logic [7:0] gp_reg [`CAS_GP_WORDS]; // General file registers
  logic [31:0] prdata_reg; // Read data

  ////////////////////////////////////////////////////////////////////
  // Control decode
  wire logic run = ctrl_reg[`CAS_CTRL_RUN];
  wire cas_mode_t mode =
    cas_mode_t'(ctrl_reg[`CAS_CTRL_MODE_HI:`CAS_CTRL_MODE_LO]);
  // Protection has no effect in mixed mode
  wire logic prot_eff = ctrl_reg[`CAS_CTRL_PROT] & (mode != MODE_MIX);
  wire logic idle = st_reg == ST_IDLE;
  wire logic exec = st_reg == ST_EXEC;
  wire cas_op_t op = ir_reg.op;

  ////////////////////////////////////////////////////////////////////
  // Data memory read side
  // Indirect access takes the address from the pointer
  wire logic [4:0] ea = ir_reg.ind ? ptr_reg[4:0] : ir_reg.fa;

  // Specials first, then the general file
  function automatic logic [7:0] dm_read(input logic [4:0] a);
    logic [4:0] gi;
    gi = a - `CAS_DM_GP_BASE;
    case (a)
      `CAS_DM_ACC: dm_read = acc_reg;
      `CAS_DM_STAT: dm_read = {4'h0, stat_reg};
      `CAS_DM_PCL: dm_read = pc_reg[7:0];
      `CAS_DM_PCH: dm_read = pc_reg[15:8];
      `CAS_DM_PTR: dm_read = ptr_reg;
      `CAS_DM_PRODL: dm_read = prod_reg[7:0];
      `CAS_DM_PRODH: dm_read = prod_reg[15:8];
      5'h07: dm_read = 8'h00; // Unused slot
      default: dm_read = gp_reg[gi];
    endcase
  endfunction

  logic [7:0] fval; // Operand read from the file
  // Process form so the read follows every register it selects
  always_comb begin
    fval = dm_read(ea);
  end

  ////////////////////////////////////////////////////////////////////
  // Adder: subtract is file plus inverted accumulator plus one
  wire logic sub = op == OP_SUB;
  wire logic [7:0] addend = sub ? ~acc_reg : acc_reg;
  wire logic [4:0] lo_sum = 5'({1'b0, fval[3:0]} + {1'b0, addend[3:0]}
    + {4'h0, sub});
  wire logic [7:0] lo7 = 8'({1'b0, fval[6:0]} + {1'b0, addend[6:0]}
    + {7'h0, sub});
  wire logic [8:0] sum9 = 9'({1'b0, fval} + {1'b0, addend}
    + {8'h0, sub});
  // Carry into bit seven against carry out of bit seven
  wire logic ovf = lo7[7] ^ sum9[8];

  ////////////////////////////////////////////////////////////////////
  // Result and flag selection
  logic [7:0] res;
  cas_flags_t fl;
  logic fl_we;
  logic core_we;
  logic [4:0] core_wa;

  // One case per group of operations; flags only where the operation owns them
  always_comb begin
    res = fval;
    fl = stat_reg;
    fl_we = 1'b0;
    core_we = 1'b0;
    core_wa = ir_reg.dst_f ? ea : `CAS_DM_ACC;
    case (op)
      OP_ADD, OP_SUB: begin
        res = sum9[7:0];
        fl.c = sum9[8];
        fl.dc = lo_sum[4];
        fl.ov = ovf;
        fl.z = sum9[7:0] == 8'h00;
        fl_we = 1'b1;
        core_we = 1'b1;
      end
      OP_AND, OP_IOR, OP_XOR, OP_MOVF: begin
        res = (op == OP_AND) ? (fval & acc_reg) :
              (op == OP_IOR) ? (fval | acc_reg) :
              (op == OP_XOR) ? (fval ^ acc_reg) : fval;
        fl.z = res == 8'h00;
        fl_we = 1'b1;
        core_we = 1'b1;
      end
      OP_RLC: begin
        res = {fval[6:0], stat_reg.c};
        fl.c = fval[7];
        fl_we = 1'b1;
        core_we = 1'b1;
      end
      OP_RRC: begin
        res = {stat_reg.c, fval[7:1]};
        fl.c = fval[0];
        fl_we = 1'b1;
        core_we = 1'b1;
      end
      OP_MOVWF: begin
        res = acc_reg;
        core_wa = ea;
        core_we = 1'b1;
      end
      OP_MOVFF: begin
        // Straight file to file, accumulator untouched
        core_wa = ir_reg.fa2;
        core_we = 1'b1;
      end
      default: begin
        res = fval;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic setup = psel & ~penable;
  wire logic acc_ph = psel & penable;
  wire logic hit_ctrl = paddr == `CAS_OFF_CTRL;
  wire logic hit_stat = paddr == `CAS_OFF_STAT;
  wire logic hit_pc = paddr == `CAS_OFF_PC;
  wire logic hit_ir = paddr == `CAS_OFF_IR;
  wire logic hit_dm = paddr[7] & (paddr[1:0] == 2'h0);
  wire logic hit_any = hit_ctrl | hit_stat | hit_pc | hit_ir | hit_dm;
  wire logic apb_wr = acc_ph & pwrite & hit_any;
  // Data space and counter writes only while halted
  wire logic apb_dm_we = apb_wr & hit_dm & idle;

  assign pready = 1'b1;
  assign pslverr = acc_ph & ~hit_any;
  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////
  // Single data memory write port
  wire logic dm_we = (exec & core_we) | apb_dm_we;
  wire logic [4:0] dm_wa = apb_dm_we ? paddr[6:2] : core_wa;
  wire logic [7:0] dm_wd = apb_dm_we ? pwdata[7:0] : res;
  wire logic [4:0] dm_gi = dm_wa - `CAS_DM_GP_BASE;
  wire logic dm_gp = dm_wa >= `CAS_DM_GP_BASE;

  ////////////////////////////////////////////////////////////////////
  // Program bus: table read borrows the fetch slot
  wire logic tbl_now = exec & (op == OP_TBLRD);
  wire logic [15:0] tbl_addr = {fval, acc_reg};
  assign pm_addr = tbl_now ? tbl_addr : pc_reg;
  assign pm_ext = (mode == MODE_EXT) |
    ((mode == MODE_MIX) & ({1'b0, pm_addr} >= `CAS_INT_WORDS));
  // Protected internal words read back as zero
  wire logic tbl_block = prot_eff & ~pm_ext;
  wire logic branch = exec & (op == OP_GOTO);
  wire logic [15:0] target = {pc_reg[15:12], ir_reg[11:0]};
  // A word is fetched on fill and on every plain execute while run is set
  wire logic fetch_now = (st_reg == ST_FILL) |
    (exec & run & ~branch & ~tbl_now);

  ////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    case (st_reg)
      ST_IDLE: st_next = run ? ST_FILL : ST_IDLE;
      ST_FILL: st_next = ST_EXEC;
      ST_EXEC: begin
        // Branch and table read refill the pipe
        if (!run) begin
          st_next = ST_IDLE;
        end else if (branch | tbl_now) begin
          st_next = ST_FILL;
        end else begin
          st_next = ST_EXEC;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // Sequencer, counter and instruction register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      pc_reg <= `CAS_RST_PC;
      ir_reg <= cas_instr_t'(16'h0000);
    end else begin
      st_reg <= st_next;
      if (apb_wr & hit_pc & idle) begin
        pc_reg <= pwdata[15:0];
      end else if (branch) begin
        pc_reg <= target;
      end else if (fetch_now) begin
        pc_reg <= pc_reg + 16'h0001;
      end
      if (fetch_now) begin
        ir_reg <= cas_instr_t'(pm_data);
      end
    end
  end

  // Control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CAS_RST_CTRL;
    end else if (apb_wr & hit_ctrl) begin
      ctrl_reg <= pwdata[3:0];
    end
  end

  // Accumulator, flags, pointer; flag update beats a data write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= `CAS_RST_BYTE;
      stat_reg <= cas_flags_t'(4'h0);
      ptr_reg <= `CAS_RST_BYTE;
    end else begin
      if (dm_we & (dm_wa == `CAS_DM_ACC)) begin
        acc_reg <= dm_wd;
      end
      if (exec & fl_we) begin
        stat_reg <= fl;
      end else if (dm_we & (dm_wa == `CAS_DM_STAT)) begin
        stat_reg <= cas_flags_t'(dm_wd[3:0]);
      end
      if (dm_we & (dm_wa == `CAS_DM_PTR)) begin
        ptr_reg <= dm_wd;
      end
    end
  end

  // Product: multiply, table word or data write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prod_reg <= 16'h0000;
    end else if (exec & (op == OP_MUL)) begin
      prod_reg <= 16'(acc_reg) * 16'(fval);
    end else if (tbl_now) begin
      prod_reg <= tbl_block ? 16'h0000 : pm_data;
    end else if (dm_we & (dm_wa == `CAS_DM_PRODL)) begin
      prod_reg[7:0] <= dm_wd;
    end else if (dm_we & (dm_wa == `CAS_DM_PRODH)) begin
      prod_reg[15:8] <= dm_wd;
    end
  end

  // General file registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CAS_GP_WORDS; i++) begin
        gp_reg[i] <= `CAS_RST_BYTE;
      end
    end else if (dm_we & dm_gp) begin
      gp_reg[dm_gi] <= dm_wd;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= hit_ctrl ? {28'h0, ctrl_reg} :
        hit_stat ? {26'h0, st_reg, stat_reg} :
        hit_pc ? {16'h0, pc_reg} :
        hit_ir ? {16'h0, ir_reg} :
        hit_dm ? {24'h0, dm_read(paddr[6:2])} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  wire logic signed [8:0] ssum =
    $signed({fval[7], fval}) + $signed({acc_reg[7], acc_reg});
  wire logic [4:0] nib = {1'b0, fval[3:0]} + {1'b0, acc_reg[3:0]};
  wire logic [7:0] add8 = 8'(fval + acc_reg);

  a_sub_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_SUB |=> stat_reg.c == ($past(fval) >= $past(acc_reg)))
    else $error("carry is not inverted borrow");
  a_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_ADD |=> stat_reg.z == ($past(add8) == 8'h00))
    else $error("zero flag wrong");
  a_ovf_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_ADD |=> stat_reg.ov == ($past(ssum) > 9'sd127 ||
      $past(ssum) < -9'sd128))
    else $error("overflow flag wrong");
  a_digit_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_ADD |=> stat_reg.dc == $past(nib[4]))
    else $error("digit carry wrong");
  a_mul_product: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_MUL |=>
      prod_reg == 16'($past(acc_reg)) * 16'($past(fval)))
    else $error("product wrong");
  a_branch_refill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    branch && run |=> st_reg == ST_FILL && pc_reg == $past(target))
    else $error("branch did not refill");
  a_fetch_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && run && !branch && !tbl_now |=> st_reg == ST_EXEC &&
      pc_reg == $past(pc_reg) + 16'h0001 && ir_reg == $past(pm_data))
    else $error("fetch did not overlap");
  a_mixed_table: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tbl_now && mode == MODE_MIX |=> prod_reg == $past(pm_data))
    else $error("mixed mode protected");
  a_acc_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_ADD && !ir_reg.dst_f |=> acc_reg == $past(add8))
    else $error("accumulator result wrong");

endmodule

// File: logic/cas_pkg.sv
// Types shared by the arithmetic core
package cas_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
    OP_IOR = 4'h4, OP_XOR = 4'h5, OP_RLC = 4'h6, OP_RRC = 4'h7,
    OP_MOVF = 4'h8, OP_MOVWF = 4'h9, OP_MOVFF = 4'ha, OP_MUL = 4'hb,
    OP_GOTO = 4'hc, OP_TBLRD = 4'hd
  } cas_op_t;
  typedef struct packed {
    cas_op_t op;
    logic dst_f;
    logic ind;
    logic [4:0] fa2;
    logic [4:0] fa;
  } cas_instr_t;
  typedef struct packed {
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cas_flags_t;
  typedef enum logic [1:0] {
    MODE_INT = 2'h0, MODE_EXT = 2'h1, MODE_MIX = 2'h2
  } cas_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_FILL = 2'h1, ST_EXEC = 2'h3
  } cas_state_t;
endpackage

// File: logic/cas_regs.svh
// Register offsets, field positions, reset values and sizes of the core
`ifndef CAS_REGS_SVH
`define CAS_REGS_SVH
// APB byte offsets
`define CAS_OFF_CTRL 8'h00
`define CAS_OFF_STAT 8'h04
`define CAS_OFF_PC 8'h08
`define CAS_OFF_IR 8'h0c
// Data memory window, one word per location
`define CAS_OFF_DMEM 8'h80
// Control field positions
`define CAS_CTRL_RUN 0
`define CAS_CTRL_MODE_LO 1
`define CAS_CTRL_MODE_HI 2
`define CAS_CTRL_PROT 3
// Status read field positions
`define CAS_STAT_FLAG_HI 3
`define CAS_STAT_ST_LO 4
`define CAS_STAT_ST_HI 5
// Data memory map of special registers
`define CAS_DM_ACC 5'h00
`define CAS_DM_STAT 5'h01
`define CAS_DM_PCL 5'h02
`define CAS_DM_PCH 5'h03
`define CAS_DM_PTR 5'h04
`define CAS_DM_PRODL 5'h05
`define CAS_DM_PRODH 5'h06
`define CAS_DM_GP_BASE 5'h08
`define CAS_GP_WORDS 24
// Reset values
`define CAS_RST_CTRL 4'h0
`define CAS_RST_PC 16'h0000
`define CAS_RST_BYTE 8'h00
// First program word that lies outside internal memory
`define CAS_INT_WORDS 17'h02000
`endif

// File: test/cas_pmem_model.sv
// Program memory model with internal and external halves
`timescale 1ns/1ps
module cas_pmem_model import cas_pkg::*; (
  input wire logic [15:0] pm_addr,
  input wire logic pm_ext,
  output logic [15:0] pm_data
);
  // Code words, loaded by the bench
  logic [15:0] prog_mem [0:63];
  ////////////////////////////////////////////////////////////////////
  // Whole word answered in the same cycle as its address
  always_comb begin
    if (pm_addr < 16'h0040) begin
      // Low words hold the program
      pm_data = prog_mem[pm_addr[5:0]];
    end else if (pm_ext) begin
      // External part answers its own pattern
      pm_data = pm_addr ^ 16'ha5c3;
    end else begin
      // Internal part differs, so a wrong select shows
      pm_data = pm_addr ^ 16'h3c5a;
    end
  end
endmodule

// File: test/cpu_alu_status_core_tb.sv
// Self-checking bench for the arithmetic core over APB
`timescale 1ns/1ps
`include "cas_regs.svh"
module cpu_alu_status_core_tb import cas_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] pm_addr;
  logic pm_ext;
  logic [15:0] pm_data;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic err;
  ////////////////////////////////////////////////////////////////////
  // Clock at 125 MHz
  always #4 ref_clk = ~ref_clk;
  cas_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_ext(pm_ext),
    .pm_data(pm_data));
  cas_pmem_model i_pm (.pm_addr(pm_addr), .pm_ext(pm_ext),
    .pm_data(pm_data));
  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One transfer: setup, access until pready, one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 16) n_mismatch++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Byte address of a data location
  function automatic logic [7:0] dm(input int l);
    return 8'h80 + 8'(4 * l);
  endfunction
  // Start at word 0, wait for progress, stop, wait for idle
  task automatic run(input logic [3:0] ctl);
    int n;
    n = 0;
    apb(1'b1, `CAS_OFF_PC, 32'h0);
    apb(1'b1, `CAS_OFF_CTRL, {28'h0, ctl | 4'h1});
    do begin
      apb(1'b0, `CAS_OFF_PC, 32'h0);
      n++;
    end while (q[15:0] === 16'h0 && n < 50);
    // Refused while running
    apb(1'b1, dm(12), 32'hee);
    apb(1'b1, `CAS_OFF_CTRL, {28'h0, ctl});
    do begin
      apb(1'b0, `CAS_OFF_STAT, 32'h0);
      n++;
    end while (q[5:4] !== 2'b00 && n < 100);
    if (n >= 100) n_mismatch++;
  endtask
  // One operation with random operands against the reference
  task automatic one(input int op);
    logic [7:0] acc, f, r, e0, e8, e9, lo;
    logic [3:0] fl, ef, mk, ctl;
    logic [15:0] ep, ta;
    logic [8:0] s;
    logic dst, ind, ext;
    acc = 8'($urandom);
    f = 8'($urandom);
    fl = 4'($urandom);
    dst = 1'($urandom);
    ind = (op != 10) && ($urandom % 2 == 1);
    ctl = {1'($urandom), 2'($urandom % 3), 1'b0};
    if (op == 13) f[0] = 1'b1;
    e0 = acc;
    e8 = f;
    e9 = 8'h5a;
    ep = 16'h0;
    mk = 4'h0;
    ef = fl;
    r = f;
    case (op)
      1: begin
        s = {1'b0, f} + {1'b0, acc};
        r = s[7:0];
        ef = {f[7] == acc[7] && r[7] != f[7], r == 8'h0,
              {1'b0, f[3:0]} + {1'b0, acc[3:0]} > 5'd15, s[8]};
        mk = 4'hf;
      end
      2: begin
        r = f - acc;
        ef = {f[7] != acc[7] && r[7] != f[7], r == 8'h0,
              f[3:0] >= acc[3:0], f >= acc};
        mk = 4'hf;
      end
      3: r = f & acc;
      4: r = f | acc;
      5: r = f ^ acc;
      6: begin
        r = {f[6:0], fl[0]};
        ef[0] = f[7];
        mk = 4'h1;
      end
      7: begin
        r = {fl[0], f[7:1]};
        ef[0] = f[0];
        mk = 4'h1;
      end
      9: e8 = acc;
      10: e9 = f;
      11: ep = 16'(acc) * 16'(f);
      13: begin
        ta = {f, acc};
        ext = ctl[2:1] == 2'd1 || (ctl[2:1] == 2'd2 && ta >= 16'h2000);
        ep = ext ? ta ^ 16'ha5c3 :
             (ctl[3] && ctl[2:1] == 2'd0) ? 16'h0 : ta ^ 16'h3c5a;
      end
      default: ;
    endcase
    // Logic operations and MOVF own only the zero flag
    if ((op >= 3 && op <= 5) || op == 8) begin
      ef[2] = r == 8'h0;
      mk = 4'h4;
    end
    if (op <= 8 && dst) e8 = r;
    if (op <= 8 && !dst) e0 = r;
    apb(1'b1, dm(0), {24'h0, acc});
    apb(1'b1, dm(1), {28'h0, fl});
    apb(1'b1, dm(4), 32'h8);
    apb(1'b1, dm(8), {24'h0, f});
    apb(1'b1, dm(9), 32'h5a);
    apb(1'b1, dm(10), {24'h0, ~f});
    apb(1'b1, dm(12), 32'h0);
    i_pm.prog_mem[0] = {4'(op), dst, ind, 5'd9, ind ? 5'd10 : 5'd8};
    i_pm.prog_mem[1] = 16'hc001;
    run(ctl);
    apb(1'b0, dm(0), 32'h0);
    chk(q, {24'h0, e0});
    apb(1'b0, dm(8), 32'h0);
    chk(q, {24'h0, e8});
    apb(1'b0, dm(9), 32'h0);
    chk(q, {24'h0, e9});
    apb(1'b0, dm(12), 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `CAS_OFF_STAT, 32'h0);
    chk({28'h0, q[3:0] & mk}, {28'h0, ef & mk});
    if (op == 11 || op == 13) begin
      apb(1'b0, dm(5), 32'h0);
      lo = q[7:0];
      apb(1'b0, dm(6), 32'h0);
      chk({16'h0, q[7:0], lo}, {16'h0, ep});
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(32'hcf146b9f));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, `CAS_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `CAS_OFF_STAT, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `CAS_OFF_PC, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    chk({31'h0, pready}, 32'h1);
    apb(1'b1, `CAS_OFF_STAT, 32'hf);
    apb(1'b0, `CAS_OFF_STAT, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `CAS_OFF_CTRL, 32'ha);
    apb(1'b0, `CAS_OFF_CTRL, 32'h0);
    chk(q, 32'ha);
    apb(1'b1, `CAS_OFF_CTRL, 32'h0);
    apb(1'b1, `CAS_OFF_PC, 32'h1ffff);
    apb(1'b0, `CAS_OFF_PC, 32'h0);
    chk(q, 32'hffff);
    apb(1'b0, dm(2), 32'h0);
    chk(q, 32'hff);
    apb(1'b0, dm(3), 32'h0);
    chk(q, 32'hff);
    // Every operation code except NOP and the branch, which each run uses
    for (int op = 1; op <= 13; op++) begin
      if (op != 12) repeat (6) one(op);
    end
    end_of_test();
  end
endmodule
